/* core/srw_top.sv */
`timescale 1ns/1ps
module srw_top #(
  parameter logic [31:0] RST_HOLD_CYC = srw_pkg::RST_HOLD_CYC,
  parameter logic [31:0] WD_OPEN_CYC = srw_pkg::WD_OPEN_CYC,
  parameter logic [31:0] WD_PULLUP_CYC = srw_pkg::WD_PULLUP_CYC,
  parameter logic [31:0] CAP_TIMEOUT_CYC = srw_pkg::CAP_TIMEOUT_CYC,
  parameter logic [31:0] CFG_EVAL_CYC = srw_pkg::CFG_EVAL_CYC,
  parameter logic [31:0] ENABLE_SETTLE_CYC = srw_pkg::ENABLE_SETTLE_CYC,
  parameter logic [31:0] STARTUP_CYC = srw_pkg::STARTUP_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // supply comparator, high while below threshold
  input wire logic undervoltage_in,
  // processor side pins
  input wire logic manual_reset_n_input,
  input wire logic watchdog_kick_input,
  input wire logic watchdog_enable_pin,
  // timeout configuration pin
  input wire logic timeout_config_pin,
  output logic cfg_pulldown_en,
  output logic cfg_charge_en,
  // open-drain reset output
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // open-drain watchdog fault output
  output logic watchdog_fault_n_output,
  output logic watchdog_fault_oe
);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [srw_pkg::SYNC_W-1:0] sync1_reg;
  logic [srw_pkg::SYNC_W-1:0] sync2_reg;
  logic uv_s;
  logic mr_n_s;
  logic kick_s;
  logic en_s;
  logic cfg_s;
  srw_pkg::srw_rst_state_type rst_state_reg;
  logic [31:0] rst_cnt_reg;
  logic reset_cause;
  logic startup_leave;
  logic uv_prev_reg;
  logic cfg_start_reg;
  logic cfg_done;
  srw_pkg::srw_mode_type cfg_mode;
  logic wd_active;
  logic wd_settling_reg;
  logic [31:0] settle_cnt_reg;
  logic [31:0] wd_cnt_reg;
  logic [31:0] fault_cnt_reg;
  logic fault_reg;
  logic kick_prev_reg;
  logic kick_fall;
  logic [31:0] wd_timeout;
  logic low_drive_reg;

  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // two-flop synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < srw_pkg::SYNC_W; gi++) begin : g_sync
      logic pin_in;
      if (gi == srw_pkg::SY_UV) begin : g_uv
        assign pin_in = undervoltage_in;
      end else if (gi == srw_pkg::SY_MR) begin : g_mr
        assign pin_in = manual_reset_n_input;
      end else if (gi == srw_pkg::SY_KICK) begin : g_kick
        assign pin_in = watchdog_kick_input;
      end else if (gi == srw_pkg::SY_EN) begin : g_en
        assign pin_in = watchdog_enable_pin;
      end else begin : g_cfg
        assign pin_in = timeout_config_pin;
      end
      // manual reset starts out inactive high
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi] <= srw_pkg::SYNC_INIT[gi];
          sync2_reg[gi] <= srw_pkg::SYNC_INIT[gi];
        end else begin
          sync1_reg[gi] <= pin_in;
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign uv_s = sync2_reg[srw_pkg::SY_UV];
  assign mr_n_s = sync2_reg[srw_pkg::SY_MR];
  assign kick_s = sync2_reg[srw_pkg::SY_KICK];
  assign en_s = sync2_reg[srw_pkg::SY_EN];
  assign cfg_s = sync2_reg[srw_pkg::SY_CFG];

  // either cause holds reset; 1 us pulses outlast the synchroniser
  assign reset_cause = uv_s | ~mr_n_s;
  assign startup_leave = (rst_state_reg == srw_pkg::SRW_ST_STARTUP) &
                         ~uv_s &
                         (rst_cnt_reg == STARTUP_CYC - srw_pkg::CNT_ONE);

  // reset sequencer: startup, hold, run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_state_reg <= srw_pkg::SRW_ST_STARTUP;
      rst_cnt_reg <= srw_pkg::CNT_ZERO;
    end else begin
      case (rst_state_reg)
        srw_pkg::SRW_ST_STARTUP: begin
          if (uv_s) begin
            rst_cnt_reg <= srw_pkg::CNT_ZERO; // needs unbroken supply
          end else if (startup_leave) begin
            rst_cnt_reg <= srw_pkg::CNT_ZERO;
            rst_state_reg <= srw_pkg::SRW_ST_ASSERT;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + srw_pkg::CNT_ONE;
          end
        end
        srw_pkg::SRW_ST_ASSERT: begin
          if (reset_cause) begin
            rst_cnt_reg <= srw_pkg::CNT_ZERO; // hold restarts
          end else if (rst_cnt_reg == RST_HOLD_CYC - srw_pkg::CNT_ONE) begin
            rst_cnt_reg <= srw_pkg::CNT_ZERO;
            rst_state_reg <= srw_pkg::SRW_ST_RUN;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + srw_pkg::CNT_ONE;
          end
        end
        srw_pkg::SRW_ST_RUN: begin
          if (reset_cause) begin
            rst_state_reg <= srw_pkg::SRW_ST_ASSERT;
          end
        end
        default: rst_state_reg <= srw_pkg::SRW_ST_STARTUP;
      endcase
    end
  end

  // reset pin driven low unless running; the cause bypasses the fsm lag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_oe <= (rst_state_reg != srw_pkg::SRW_ST_RUN) |
                      reset_cause;
    end
  end

  // a start pulse on each entry into the valid supply region
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_prev_reg <= 1'b1;
      cfg_start_reg <= 1'b0;
    end else begin
      uv_prev_reg <= uv_s;
      cfg_start_reg <= startup_leave |
                       (uv_prev_reg & ~uv_s &
                        (rst_state_reg != srw_pkg::SRW_ST_STARTUP));
    end
  end

  srw_cfg_eval #(
    .PHASE_CYC(CFG_EVAL_CYC >> 1)
  ) u_cfg_eval (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(cfg_start_reg),
    .pin_level(cfg_s),
    .pulldown_en(cfg_pulldown_en),
    .charge_en(cfg_charge_en),
    .mode(cfg_mode),
    .done(cfg_done)
  );

  // timeout source follows the classified pin
  always_comb begin
    case (cfg_mode)
      srw_pkg::SRW_MODE_OPEN: wd_timeout = WD_OPEN_CYC;
      srw_pkg::SRW_MODE_PULLUP: wd_timeout = WD_PULLUP_CYC;
      srw_pkg::SRW_MODE_CAP: wd_timeout = CAP_TIMEOUT_CYC;
      default: wd_timeout = WD_OPEN_CYC;
    endcase
  end

  // watchdog runs only out of reset, enabled and configured
  assign wd_active = (rst_state_reg == srw_pkg::SRW_ST_RUN) &
                     ~reset_cause & en_s & cfg_done;
  assign kick_fall = kick_prev_reg & ~kick_s;

  // kick edge history; the 50 ns minimum pulse clears two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_s;
    end
  end

  // watchdog timer, settle window and fault hold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_settling_reg <= 1'b1;
      settle_cnt_reg <= srw_pkg::CNT_ZERO;
      wd_cnt_reg <= srw_pkg::CNT_ZERO;
      fault_cnt_reg <= srw_pkg::CNT_ZERO;
      fault_reg <= 1'b0;
    end else if (!wd_active) begin
      // disabled or in reset: kicks ignored, fault released
      wd_settling_reg <= 1'b1;
      settle_cnt_reg <= srw_pkg::CNT_ZERO;
      wd_cnt_reg <= srw_pkg::CNT_ZERO;
      fault_cnt_reg <= srw_pkg::CNT_ZERO;
      fault_reg <= 1'b0;
    end else if (wd_settling_reg) begin
      if (settle_cnt_reg == ENABLE_SETTLE_CYC - srw_pkg::CNT_ONE) begin
        wd_settling_reg <= 1'b0; // kicks heard from here on
      end else begin
        settle_cnt_reg <= settle_cnt_reg + srw_pkg::CNT_ONE;
      end
    end else if (fault_reg) begin
      if (fault_cnt_reg == RST_HOLD_CYC - srw_pkg::CNT_ONE) begin
        fault_reg <= 1'b0; // released after one hold period
        fault_cnt_reg <= srw_pkg::CNT_ZERO;
        wd_cnt_reg <= srw_pkg::CNT_ZERO;
      end else begin
        fault_cnt_reg <= fault_cnt_reg + srw_pkg::CNT_ONE;
      end
    end else if (kick_fall) begin
      wd_cnt_reg <= srw_pkg::CNT_ZERO; // service restarts the count
    end else if (wd_cnt_reg == wd_timeout - srw_pkg::CNT_ONE) begin
      fault_reg <= 1'b1; // kick missed
      fault_cnt_reg <= srw_pkg::CNT_ZERO;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + srw_pkg::CNT_ONE;
    end
  end

  // open-drain pins only ever drive low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_drive_reg <= 1'b0;
    end else begin
      low_drive_reg <= 1'b0;
    end
  end
  assign reset_pin_out = low_drive_reg;
  assign watchdog_fault_n_output = low_drive_reg;
  assign watchdog_fault_oe = fault_reg;

endmodule

/* common/srw_pkg.sv */
package srw_pkg;

  // clock rate and printed times, each in its own unit
  localparam int CLK_MHZ = 200;
  localparam int RST_HOLD_MS = 200;
  localparam int WD_OPEN_MS = 1600;
  localparam int WD_PULLUP_MS = 200;
  localparam int CAP_TIMEOUT_MS = 100;
  localparam int CFG_EVAL_US = 381;
  localparam int ENABLE_SETTLE_US = 150;
  localparam int STARTUP_US = 300;

  // derived cycle counts
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] RST_HOLD_CYC =
    CNT_W'(RST_HOLD_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] WD_OPEN_CYC =
    CNT_W'(WD_OPEN_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] WD_PULLUP_CYC =
    CNT_W'(WD_PULLUP_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] CAP_TIMEOUT_CYC =
    CNT_W'(CAP_TIMEOUT_MS * CLK_MHZ * 1000);
  localparam logic [CNT_W-1:0] CFG_EVAL_CYC =
    CNT_W'(CFG_EVAL_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ENABLE_SETTLE_CYC =
    CNT_W'(ENABLE_SETTLE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] STARTUP_CYC =
    CNT_W'(STARTUP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

  // synchroniser bit positions and reset values
  localparam int SYNC_W = 5;
  localparam int SY_UV = 0;
  localparam int SY_MR = 1;
  localparam int SY_KICK = 2;
  localparam int SY_EN = 3;
  localparam int SY_CFG = 4;
  localparam logic [SYNC_W-1:0] SYNC_INIT = 5'h02;

  typedef enum logic [2:0] {
    SRW_MODE_OPEN = 3'h1,
    SRW_MODE_PULLUP = 3'h2,
    SRW_MODE_CAP = 3'h4
  } srw_mode_type;

  typedef enum logic [2:0] {
    SRW_ST_STARTUP = 3'h1,
    SRW_ST_ASSERT = 3'h2,
    SRW_ST_RUN = 3'h4
  } srw_rst_state_type;

  typedef enum logic [3:0] {
    SRW_CE_IDLE = 4'h1,
    SRW_CE_PULL = 4'h2,
    SRW_CE_CHARGE = 4'h4,
    SRW_CE_DONE = 4'h8
  } srw_cfg_state_type;

endpackage

/* core/srw_cfg_eval.sv */
`timescale 1ns/1ps
module srw_cfg_eval #(
  parameter logic [31:0] PHASE_CYC = 32'h0000_0001
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic pin_level,
  // pin drive and result
  output logic pulldown_en,
  output logic charge_en,
  output srw_pkg::srw_mode_type mode,
  output logic done
);

  srw_pkg::srw_cfg_state_type state_reg;
  logic [31:0] cnt_reg;

  // up to two equal phases: weak pull-down, then charge current if the pin reads low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= srw_pkg::SRW_CE_IDLE;
      cnt_reg <= srw_pkg::CNT_ZERO;
      mode <= srw_pkg::SRW_MODE_OPEN;
    end else if (start) begin
      state_reg <= srw_pkg::SRW_CE_PULL; // restart on every entry
      cnt_reg <= srw_pkg::CNT_ZERO;
    end else begin
      case (state_reg)
        srw_pkg::SRW_CE_PULL: begin
          if (cnt_reg == PHASE_CYC - srw_pkg::CNT_ONE) begin
            cnt_reg <= srw_pkg::CNT_ZERO;
            if (pin_level) begin
              mode <= srw_pkg::SRW_MODE_PULLUP; // beats pull-down
              state_reg <= srw_pkg::SRW_CE_DONE;
            end else begin
              state_reg <= srw_pkg::SRW_CE_CHARGE;
            end
          end else begin
            cnt_reg <= cnt_reg + srw_pkg::CNT_ONE;
          end
        end
        srw_pkg::SRW_CE_CHARGE: begin
          if (cnt_reg == PHASE_CYC - srw_pkg::CNT_ONE) begin
            cnt_reg <= srw_pkg::CNT_ZERO;
            state_reg <= srw_pkg::SRW_CE_DONE;
            // an open pin charges at once, a capacitor stays low
            mode <= pin_level ? srw_pkg::SRW_MODE_OPEN
                              : srw_pkg::SRW_MODE_CAP;
          end else begin
            cnt_reg <= cnt_reg + srw_pkg::CNT_ONE;
          end
        end
        srw_pkg::SRW_CE_DONE: state_reg <= srw_pkg::SRW_CE_DONE;
        default: state_reg <= srw_pkg::SRW_CE_IDLE;
      endcase
    end
  end

  // pin stimulus and completion flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_en <= 1'b0;
      charge_en <= 1'b0;
      done <= 1'b0;
    end else begin
      pulldown_en <= (state_reg == srw_pkg::SRW_CE_PULL) & ~start;
      charge_en <= (state_reg == srw_pkg::SRW_CE_CHARGE) & ~start;
      done <= (state_reg == srw_pkg::SRW_CE_DONE) & ~start;
    end
  end

endmodule

/* bench/srw_sva.sv */
`timescale 1ns/1ps
module srw_sva #(
  parameter logic [31:0] RST_HOLD_CYC = 32'h0000_0014,
  parameter logic [31:0] WD_PULLUP_CYC = 32'h0000_0020
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins in
  input wire logic undervoltage_in,
  input wire logic manual_reset_n_input,
  input wire logic watchdog_kick_input,
  input wire logic watchdog_enable_pin,
  // pins out
  input wire logic cfg_pulldown_en,
  input wire logic cfg_charge_en,
  input wire logic reset_pin_oe,
  input wire logic watchdog_fault_oe
);
  logic [31:0] quiet_reg;
  logic [31:0] gap_reg;
  logic [31:0] flen_reg;
  logic kick_reg;
  logic seen_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // cycles since a reset cause was last at the pins, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst || undervoltage_in || !manual_reset_n_input)
      quiet_reg <= 32'h0000_0000;
    else if (quiet_reg < 32'h0000_ffff)
      quiet_reg <= quiet_reg + 32'h0000_0001;
  end

  // cycles since the watchdog last had reason to restart its count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= 32'h0000_0000;
      seen_reg <= 1'b0;
      kick_reg <= 1'b1;
    end else begin
      kick_reg <= watchdog_kick_input;
      if ((kick_reg && !watchdog_kick_input) || reset_pin_oe ||
          !watchdog_enable_pin) begin
        gap_reg <= 32'h0000_0000;
        seen_reg <= 1'b0;
      end else begin
        if (gap_reg < 32'h0000_ffff)
          gap_reg <= gap_reg + 32'h0000_0001;
        seen_reg <= seen_reg | watchdog_fault_oe;
      end
    end
  end

  // length of the current fault pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst || !watchdog_fault_oe)
      flen_reg <= 32'h0000_0000;
    else
      flen_reg <= flen_reg + 32'h0000_0001;
  end

  sequence s_pull_phase;
    (cfg_pulldown_en && !cfg_charge_en)[*8] ##1 !cfg_pulldown_en;
  endsequence

  a_uv_asserts: assert property (undervoltage_in[*4] |=> reset_pin_oe)
    else $error("reset not driven during undervoltage");
  a_manual_asserts: assert property (
    !manual_reset_n_input[*4] |=> reset_pin_oe)
    else $error("reset not driven during manual reset");
  a_hold_min: assert property (
    $fell(reset_pin_oe) |-> quiet_reg >= RST_HOLD_CYC)
    else $error("reset released before hold period");
  a_release_bound: assert property (
    quiet_reg == RST_HOLD_CYC + 32'h0000_0020 |-> !reset_pin_oe)
    else $error("reset held too long");
  a_fault_off_rst: assert property (
    reset_pin_oe[*2] |-> !watchdog_fault_oe)
    else $error("fault driven while reset asserted");
  a_fault_len: assert property (
    $fell(watchdog_fault_oe) && !reset_pin_oe && watchdog_enable_pin &&
    $past(watchdog_enable_pin, 4) |-> flen_reg == RST_HOLD_CYC)
    else $error("fault pulse length wrong");
  a_no_early_fault: assert property (
    $rose(watchdog_fault_oe) |-> gap_reg >= WD_PULLUP_CYC)
    else $error("fault before shortest timeout");
  a_fault_due: assert property (
    gap_reg == 32'h0000_0070 |-> seen_reg || watchdog_fault_oe)
    else $error("no fault after missed kicks");
  a_enable_off: assert property (
    !watchdog_enable_pin[*4] |=> !watchdog_fault_oe)
    else $error("fault while watchdog disabled");
  a_cfg_phase: assert property ($rose(cfg_pulldown_en) |-> s_pull_phase)
    else $error("config pull-down phase wrong");
endmodule

bind srw_top srw_sva #(
  .RST_HOLD_CYC(RST_HOLD_CYC),
  .WD_PULLUP_CYC(WD_PULLUP_CYC)
) srw_sva_i (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .undervoltage_in(undervoltage_in),
  .manual_reset_n_input(manual_reset_n_input),
  .watchdog_kick_input(watchdog_kick_input),
  .watchdog_enable_pin(watchdog_enable_pin),
  .cfg_pulldown_en(cfg_pulldown_en),
  .cfg_charge_en(cfg_charge_en),
  .reset_pin_oe(reset_pin_oe),
  .watchdog_fault_oe(watchdog_fault_oe)
);

/* bench/srw_host.sv */
`timescale 1ns/1ps
module srw_host (
  // clock and control
  input wire logic sys_clk,
  input wire logic kick_en,
  input wire logic [7:0] period,
  // kick pin
  output logic watchdog_kick_input
);
  logic [7:0] cnt_reg = 8'h00;

  initial watchdog_kick_input = 1'b1;

  // low for half the period, so each level lasts 20 ns or more at the bench periods
  // one falling edge per period, kept below the shortest timeout
  // idles high when stopped, so stopping makes no falling edge
  always @(posedge sys_clk) begin
    if (!kick_en || cnt_reg >= period - 8'h01)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
    watchdog_kick_input <= !kick_en || (cnt_reg >= (period >> 1));
  end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  localparam logic [31:0] SETTLE = 32'h0000_0008;
  localparam logic [31:0] W_OPEN = 32'h0000_0040;
  localparam logic [31:0] W_PULL = 32'h0000_0020;
  localparam logic [31:0] W_CAP = 32'h0000_0030;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic uv = 1'b0;
  logic mr_n = 1'b1;
  logic en = 1'b1;
  logic kick_en = 1'b0;
  logic [7:0] period = 8'h10;
  logic [1:0] cfg_sel = 2'h0;
  logic cfg_pin, pd_en, ch_en, rst_oe, wdo_oe, kick;
  logic rst_out, wdo_out;
  logic kick_d = 1'b1;
  int since_fall = 0;
  int n_fail = 0;
  int n_checks = 0;
  int n, m, t;

  always #2.5 sys_clk = ~sys_clk;

  // config pin: pull-up wins, open pin follows pull-down, capacitor stays low
  assign cfg_pin = (cfg_sel == 2'h1) ? 1'b1 : (cfg_sel == 2'h0) ? ~pd_en : 1'b0;

  // cycles since the last kick falling edge at the pin
  always @(posedge sys_clk) begin
    kick_d <= kick;
    since_fall <= (kick_d && !kick) ? 0 : since_fall + 1;
  end

  srw_top #(
    .RST_HOLD_CYC(HOLD), .WD_OPEN_CYC(W_OPEN), .WD_PULLUP_CYC(W_PULL),
    .CAP_TIMEOUT_CYC(W_CAP), .CFG_EVAL_CYC(32'h0000_0010),
    .ENABLE_SETTLE_CYC(SETTLE), .STARTUP_CYC(32'h0000_000a)
  ) srw_top_i (
    .sys_clk(sys_clk), .nrst(nrst), .undervoltage_in(uv),
    .manual_reset_n_input(mr_n), .watchdog_kick_input(kick),
    .watchdog_enable_pin(en), .timeout_config_pin(cfg_pin),
    .cfg_pulldown_en(pd_en), .cfg_charge_en(ch_en),
    .reset_pin_out(rst_out),
    .reset_pin_oe(rst_oe), .watchdog_fault_n_output(wdo_out),
    .watchdog_fault_oe(wdo_oe)
  );

  srw_host srw_host_i (
    .sys_clk(sys_clk), .kick_en(kick_en), .period(period),
    .watchdog_kick_input(kick)
  );

  // timeout each config setting should give
  function automatic int wd_cycles(input logic [1:0] sel);
    return (sel == 2'h1) ? W_PULL : (sel == 2'h2) ? W_CAP : W_OPEN;
  endfunction

  task automatic check_bit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_span(input string what, input int lo, input int hi,
                            input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // bounded wait for an output enable to reach a level; reads at the edge
  // see the value the previous edge launched, so stimulus stays on the edge
  task automatic until_oe(input bit fault, input logic v, output int cnt);
    cnt = 0;
    while ((fault ? wdo_oe : rst_oe) !== v && cnt < 2000) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    n = $urandom(630);
    tick(10);
    nrst <= 1'b1;
    // supply dip per config setting, kicked run, then starved watchdog
    for (m = 0; m < 3; m++) begin
      cfg_sel <= m[1:0];
      uv <= 1'b1;
      tick(4 + $urandom % 8); // dip outlasts the synchroniser
      check_bit("reset on dip", 1'b1, rst_oe);
      check_bit("reset pin level", 1'b0, rst_oe ? rst_out : 1'b1);
      uv <= 1'b0;
      kick_en <= 1'b1;
      period <= 8'(8 + $urandom % 16);
      until_oe(1'b0, 1'b0, n);
      check_span("reset hold", HOLD, HOLD + 24, n);
      tick(200);
      check_bit("fault while kicked", 1'b0, wdo_oe);
      kick_en <= 1'b0;
      t = wd_cycles(m[1:0]);
      until_oe(1'b1, 1'b1, n);
      check_span("fault delay", t, t + 8, since_fall);
      check_bit("fault pin level", 1'b0, wdo_oe ? wdo_out : 1'b1);
      until_oe(1'b1, 1'b0, n);
      check_span("fault width", HOLD - 1, HOLD + 1, n);
    end
    // manual reset while the host keeps kicking
    kick_en <= 1'b1;
    mr_n <= 1'b0;
    tick(4 + $urandom % 12); // manual pulse held long enough
    check_bit("reset on manual", 1'b1, rst_oe);
    check_bit("fault in reset", 1'b0, wdo_oe);
    mr_n <= 1'b1;
    until_oe(1'b0, 1'b0, n);
    check_span("manual release", HOLD, HOLD + 6, n);
    // watchdog off without kicks, then on again
    kick_en <= 1'b0;
    en <= 1'b0;
    tick(150);
    check_bit("fault while off", 1'b0, wdo_oe);
    en <= 1'b1;
    until_oe(1'b1, 1'b1, n);
    check_span("fault after on", W_CAP + SETTLE, W_CAP + SETTLE + 8, n);
    wrap_up();
  end

  // cut a hang short; the tests need about 1200 cycles
  initial begin
    tick(20000);
    n_fail++;
    wrap_up();
  end
endmodule
